// [bench/ctos_enc_model.sv]
// Purpose: Encoder counter partner feeding count value, pulse and direction
// Assumes: One step or one preset load per request cycle
// Notes:   Direction line toggles when idle, so it is never trusted outside pulses
`timescale 1ns/1ps
`default_nettype none
module ctos_enc_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        step_i,
    input  wire logic        fwd_i,
    input  wire logic        load_i,
    input  wire logic [31:0] load_val_i,
    output var  logic [31:0] value_o,
    output var  logic        pulse_o,
    output var  logic        dir_o
);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            value_o <= 32'h0;
            pulse_o <= 1'b0;
            dir_o   <= 1'b0;
        end else begin
            pulse_o <= step_i && !load_i;
            dir_o   <= step_i ? fwd_i : ~dir_o;
            if (load_i) begin
                value_o <= load_val_i;
            end else if (step_i) begin
                value_o <= fwd_i ? value_o + 32'h1 : value_o - 32'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [bench/ctos_top_assertions.sv]
// Purpose: Port-level checks for the threshold output switch
// Assumes: One clock domain
// Notes:   Output changes must trace back to a pulse or a register write
`timescale 1ns/1ps
`default_nettype none
module ctos_top_assertions (
    input wire logic                        mclk_i,
    input wire logic                        arst_n_i,
    input wire logic                        ce_i,
    input wire logic                        psel_i,
    input wire logic                        penable_i,
    input wire logic                        pwrite_i,
    input wire logic [ctos_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [ctos_pkg::DATA_W-1:0] prdata_o,
    input wire logic                        pready_o,
    input wire logic                        pslverr_o,
    input wire logic                        count_pulse_i,
    input wire logic [ctos_pkg::CH_NUM-1:0] out_o
);
    import ctos_pkg::*;
    logic bad;
    assign bad = paddr_i[7] || paddr_i[1:0] != 2'h0 || paddr_i[5:4] == 2'h1;
    default clocking ck @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    wait_one_a: assert property (psel_i && penable_i && !pready_o && ce_i |=> pready_o)
        else $error("ready late");
    ready_pulse_a: assert property (pready_o && ce_i |=> !pready_o) else $error("ready stuck");
    ready_sel_a: assert property (pready_o |-> psel_i && penable_i) else $error("stray ready");
    err_ready_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
    err_zero_a: assert property (pslverr_o |-> prdata_o == 32'h0) else $error("error data");
    bad_addr_a: assert property (pready_o && bad |-> pslverr_o) else $error("no error");
    good_addr_a: assert property (pready_o && !bad |-> !pslverr_o) else $error("false error");
    out_cause_a: assert property ($changed(out_o) |-> $past(count_pulse_i) ||
        $past(pready_o && pwrite_i, 2)) else $error("output moved without cause");
    ch0_own_a: assert property ($changed(out_o[0]) |-> $past(count_pulse_i) ||
        $past(pready_o && pwrite_i && !paddr_i[6], 2)) else $error("channel 0 disturbed");
    ch1_own_a: assert property ($changed(out_o[1]) |-> $past(count_pulse_i) ||
        $past(pready_o && pwrite_i && paddr_i[6], 2)) else $error("channel 1 disturbed");
    cover property (pready_o && pslverr_o);
    cover property ($rose(out_o[0]));
    cover property ($rose(out_o[1]));
endmodule
bind ctos_top ctos_top_assertions ctos_top_assertions_inst (.mclk_i, .arst_n_i, .ce_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .count_pulse_i, .out_o);
`default_nettype wire

// [bench/ctos_top_tb.sv]
// Purpose: Self-checking bench for the threshold output switch
// Assumes: Channel 0 at byte 8'h00, channel 1 at 8'h40
// Notes:   Register reads are checked from a queue by a monitor
`timescale 1ns/1ps
`default_nettype none
module ctos_top_tb;
    logic        mclk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ce = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, lval = 32'h0, prdata, cval;
    logic        step = 1'b0, fwd = 1'b0, load = 1'b0, pready, pslverr, pulse, cdir;
    logic [1:0]  out;
    logic [33:0] exp_q[$];
    int          err_total = 0, samples_checked = 0, seed;
    always #4 mclk = ~mclk;
    ctos_top ctos_top_inst (.mclk_i(mclk), .arst_n_i(arst_n), .ce_i(ce), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .count_value_i(cval),
        .count_pulse_i(pulse), .count_dir_i(cdir), .out_o(out));
    ctos_enc_model ctos_enc_model_inst (.clk_i(mclk), .rst_n_i(arst_n), .step_i(step),
        .fwd_i(fwd), .load_i(load), .load_val_i(lval), .value_o(cval), .pulse_o(pulse),
        .dir_o(cdir));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic fail(input logic [33:0] e, input logic [33:0] g);
        err_total++;
        $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    endtask
    task automatic cmp_apb(input logic [33:0] n);
        samples_checked++;
        if (pslverr !== n[32] || (n[33] && prdata !== n[31:0])) fail(n, {n[33], pslverr, prdata});
    endtask
    task automatic cmp_out(input logic [1:0] e);
        @(posedge mclk);
        samples_checked++;
        if (out !== e) fail({32'h0, e}, {32'h0, out});
    endtask
    // Holds the request until ready is sampled, bounded wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] ex, input logic er);
        int n;
        n = 0;
        exp_q.push_back({~w, er, ex});
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fail(34'h0, 34'h0);
        psel <= 1'b0; penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask
    task automatic mv(input logic d);
        step <= 1'b1; fwd <= d;
        @(posedge mclk);
        step <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic ld(input logic [31:0] v);
        load <= 1'b1; lval <= v;
        @(posedge mclk);
        load <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic run(input logic [7:0] d, input logic [7:0] e, input int n, input logic hi);
        for (int i = 0; i < n; i++) begin
            mv(d[i]);
            cmp_out({hi, e[i]});
        end
    endtask
    always @(posedge mclk) begin
        if (pready === 1'b1) begin
            if (exp_q.size() == 0) fail(34'h0, {2'h3, prdata});
            else cmp_apb(exp_q.pop_front());
        end
    end
    initial begin
        #40000;
        fail(34'h0, 34'h1);
        print_verdict();
    end
    initial begin
        seed = $urandom(32'hD59CA512);
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        apb(1'b0, 8'h00, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
        apb(1'b0, 8'h80, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h14, $urandom, 32'h0, 1'b1);
        wr(8'h04, 32'h9);
        apb(1'b0, 8'h04, 32'h0, 32'h8, 1'b0);
        $display("registers done");
        wr(8'h20, 32'h3); wr(8'h24, 32'h5); wr(8'h28, 32'h4);
        for (int i = 0; i < 5; i++) wr(8'h2C + 8'(4 * i), $urandom | 32'h100);
        wr(8'h08, 32'h5);
        wr(8'h04, 32'h2);
        wr(8'h00, 32'h3);
        cmp_out(2'h0);
        run(8'h1F, 8'h4C, 7, 1'b0);
        $display("stepping done");
        ld(32'h5);
        cmp_out(2'h1);
        run(8'h01, 8'h01, 1, 1'b0);
        $display("preset done");
        wr(8'h00, 32'h1);
        cmp_out(2'h1);
        wr(8'h00, 32'hB);
        cmp_out(2'h0);
        run(8'h18, 8'h1C, 5, 1'b0);
        wr(8'h00, 32'h1);
        wr(8'h00, 32'h13);
        cmp_out(2'h1);
        run(8'h01, 8'h03, 2, 1'b0);
        $display("direction done");
        wr(8'h60, 32'h0); wr(8'h48, 32'h1); wr(8'h44, 32'h1); wr(8'h40, 32'h2);
        cmp_out(2'h1);
        ld(32'h1);
        run(8'h00, 8'h01, 1, 1'b1);
        $display("second channel done");
        wr(8'h48, 32'h0);
        wr(8'h40, 32'h102);
        run(8'h01, 8'h03, 2, 1'b1);
        wr(8'h40, 32'h2);
        mv(1'b1);
        run(8'h00, 8'h01, 1, 1'b0);
        $display("reference done");
        wr(8'h48, 32'h1);
        ld(32'h1);
        ce <= 1'b0;
        mv(1'b0);
        ce <= 1'b1;
        cmp_out(2'h1);
        mv(1'b1);
        mv(1'b0);
        cmp_out(2'h3);
        $display("clock enable done");
        print_verdict();
    end
endmodule
`default_nettype wire

// [rtl/ctos_pkg.sv]
// Purpose: Shared constants for the counter threshold output switch
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes:   Channel c occupies byte window c * 64, selected by address bit CH_BIT
package ctos_pkg;
    localparam int          CH_NUM        = 2;
    localparam int          THR_NUM       = 8;
    localparam int          DATA_W        = 32;
    localparam int          ADDR_W        = 8;
    localparam int          CNT_W         = 4;
    localparam int          REF_W         = 2;
    localparam int          THR_IDX_W     = 3;
    localparam int          CH_BIT        = 6;
    // Register offsets inside one channel window
    localparam logic [5:0]  OFS_CTRL      = 6'h00;
    localparam logic [5:0]  OFS_COUNT     = 6'h04;
    localparam logic [5:0]  OFS_LEVEL     = 6'h08;
    localparam logic [5:0]  OFS_STATUS    = 6'h0C;
    localparam int          OFS_THR_BIT   = 5;
    // Control fields
    localparam int          CTRL_MAN      = 0;
    localparam int          CTRL_EN       = 1;
    localparam int          CTRL_FWD_DIS  = 3;
    localparam int          CTRL_BWD_DIS  = 4;
    localparam int          CTRL_REF_LSB  = 8;
    localparam logic [1:0]  REF_COUNTER   = 2'h0;
    // Status fields
    localparam int          STAT_OUT      = 0;
    localparam int          STAT_VALID    = 1;
    localparam int          STAT_DIR      = 2;
    localparam int          STAT_DIR_SEEN = 3;
    // Reset values and limits
    localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
    localparam logic [3:0]  COUNT_RST     = 4'h0;
    localparam logic [3:0]  COUNT_MAX     = 4'h8;
    localparam logic [7:0]  LEVEL_RST     = 8'h00;
    localparam logic [31:0] THR_RST       = 32'h0000_0000;
endpackage

// [rtl/ctos_top.sv]
// Purpose: Two independent encoder-driven threshold output channels with APB access
// Assumes: Encoder counter runs on mclk_i; count_pulse_i marks a counting step
// Notes:   Preset loads never reach this block as pulses, so they never switch
`timescale 1ns/1ps
`default_nettype none

// Operation
// - There are two independent channels, index 0 driving the first output and 1 the second.
// - With the reference selector at zero a channel compares its thresholds with the counter.
// - While automatic switching is enabled the manual output bit is ignored.
// - Enabling at standstill restores the last known switching state, or FALSE if none exists.
// - The active count goes up to eight and always activates thresholds one to k.
// - With forward disable clear, positive counting switches on thresholds one to eight.
// - With forward disable set and positive motion at enable time the output goes FALSE.
// - With backward disable clear, negative counting switches on thresholds one to eight.
// - With backward disable set and negative motion at enable time the output goes FALSE.
// - Enabling at standstill with a disabled direction uses the last observed direction.
// - Only a counting pulse reaching a threshold switches the output.
// - Loading a preset counter value never switches the output.
// - Each channel holds eight 32-bit thresholds and zero is a legal threshold.
// - Each threshold has its own programmable output level applied when it is reached.
// - With zero duration the applied level stays until the next threshold is reached.
module ctos_top (
    input  wire logic                         mclk_i,
    input  wire logic                         arst_n_i,
    input  wire logic                         ce_i,
    input  wire logic                         psel_i,
    input  wire logic                         penable_i,
    input  wire logic                         pwrite_i,
    input  wire logic [ctos_pkg::ADDR_W-1:0]  paddr_i,
    input  wire logic [ctos_pkg::DATA_W-1:0]  pwdata_i,
    output logic      [ctos_pkg::DATA_W-1:0]  prdata_o,
    output logic                              pready_o,
    output logic                              pslverr_o,
    input  wire logic [ctos_pkg::DATA_W-1:0]  count_value_i,
    input  wire logic                         count_pulse_i,
    input  wire logic                         count_dir_i,
    output logic      [ctos_pkg::CH_NUM-1:0]  out_o
);
    import ctos_pkg::*;

    logic                rst_meta;
    logic                rst_sync_n;
    logic                next_rst_meta;
    logic                next_rst_sync_n;

    logic [DATA_W-1:0]   prdata;
    logic                pready;
    logic                pslverr;
    logic [DATA_W-1:0]   next_prdata;
    logic                next_pready;
    logic                next_pslverr;
    logic                wr_en;
    logic                ch_sel;
    logic [5:0]          ofs;
    logic                ofs_ok;
    logic                sel_ctrl;
    logic                sel_count;
    logic                sel_level;
    logic                sel_status;
    logic                sel_thr;
    logic [THR_IDX_W-1:0] thr_idx;
    logic [DATA_W-1:0]   rd_word [CH_NUM];
    logic [CH_NUM-1:0]   out_q;

    // Only the second stage is read by logic
    always_comb begin
        next_rst_meta   = 1'b1;
        next_rst_sync_n = rst_meta;
    end

    // Async assert, clocked release
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= next_rst_meta;
            rst_sync_n <= next_rst_sync_n;
        end
    end

    // Channel from the window bit, offset within the window
    assign ch_sel = paddr_i[CH_BIT];
    assign ofs    = paddr_i[5:0];

    // One decode shared by error check, writes and reads
    assign sel_ctrl   = (ofs == OFS_CTRL);
    assign sel_count  = (ofs == OFS_COUNT);
    assign sel_level  = (ofs == OFS_LEVEL);
    assign sel_status = (ofs == OFS_STATUS);
    assign sel_thr    = ofs[OFS_THR_BIT];
    assign thr_idx    = ofs[OFS_THR_BIT-1:2];
    assign ofs_ok = (paddr_i[ADDR_W-1] == 1'b0) && (ofs[1:0] == 2'b00)
                  && (sel_thr || sel_ctrl || sel_count || sel_level || sel_status);
    // Write lands only at the completing edge
    assign wr_en  = psel_i && penable_i && pready && pwrite_i && ofs_ok;

    // One wait state keeps read data registered
    always_comb begin
        next_pready  = 1'b0;
        next_prdata  = prdata;
        next_pslverr = 1'b0;
        if (psel_i && penable_i && !pready) begin
            next_pready  = 1'b1;
            next_pslverr = !ofs_ok;
            next_prdata  = (ofs_ok && !pwrite_i) ? rd_word[ch_sel] : '0;
        end
    end

    // ce_i low stalls the answer as well
    always_ff @(posedge mclk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce_i) begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    assign prdata_o  = prdata;
    assign pready_o  = pready;
    assign pslverr_o = pslverr;
    assign out_o     = out_q;

    for (genvar c = 0; c < CH_NUM; c++) begin : g_ch
        logic [DATA_W-1:0]  ctrl;
        logic [CNT_W-1:0]   cnt;
        logic [THR_NUM-1:0] lvl;
        logic [DATA_W-1:0]  thr [THR_NUM];
        logic               out_lvl;
        logic               last_state;
        logic               state_valid;
        logic               last_dir;
        logic               dir_seen;
        logic               en_d;

        logic [DATA_W-1:0]  next_ctrl;
        logic [CNT_W-1:0]   next_cnt;
        logic [THR_NUM-1:0] next_lvl;
        logic [DATA_W-1:0]  next_thr [THR_NUM];
        logic               next_out_lvl;
        logic               next_last_state;
        logic               next_state_valid;
        logic               next_last_dir;
        logic               next_dir_seen;
        logic               next_en_d;

        logic [THR_NUM-1:0] match;
        logic               hit;
        logic               hit_lvl;
        logic               auto_on;
        logic               en_rise;
        logic               dir_dis;
        logic               old_dis;
        logic               restore;
        logic               ch_wr;
        logic               wr_ctrl;
        logic               wr_count;
        logic               wr_level;
        logic               wr_thr;

        for (genvar i = 0; i < THR_NUM; i++) begin : g_thr
            // Zero compares like any other value
            assign match[i] = (CNT_W'(i) < cnt) && (count_value_i == thr[i]);
        end

        always_comb begin
            hit     = 1'b0;
            hit_lvl = 1'b0;
            // Lowest active index wins on duplicates
            for (int i = THR_NUM - 1; i >= 0; i--) begin
                if (match[i]) begin
                    hit     = 1'b1;
                    hit_lvl = lvl[i];
                end
            end
        end

        assign ch_wr   = wr_en && (ch_sel == 1'(c));
        assign wr_ctrl  = ch_wr && sel_ctrl;
        assign wr_count = ch_wr && sel_count;
        assign wr_level = ch_wr && sel_level;
        assign wr_thr   = ch_wr && sel_thr;

        assign auto_on = ctrl[CTRL_EN]
                       && (ctrl[CTRL_REF_LSB +: REF_W] == REF_COUNTER);
        // First cycle in which ctrl shows enable
        assign en_rise = ctrl[CTRL_EN] && !en_d;
        assign dir_dis = count_dir_i ? ctrl[CTRL_FWD_DIS] : ctrl[CTRL_BWD_DIS];
        // Standstill enable falls back on the last seen direction
        assign old_dis = dir_seen && (last_dir ? ctrl[CTRL_FWD_DIS] : ctrl[CTRL_BWD_DIS]);
        // No recorded state yet means FALSE
        assign restore = state_valid ? last_state : 1'b0;

        always_comb begin
            next_ctrl        = ctrl;
            next_cnt         = cnt;
            next_lvl         = lvl;
            next_thr         = thr;
            next_out_lvl     = out_lvl;
            next_last_state  = last_state;
            next_state_valid = state_valid;
            next_last_dir    = last_dir;
            next_dir_seen    = dir_seen;
            next_en_d        = ctrl[CTRL_EN];
            if (wr_thr) begin
                next_thr[thr_idx] = pwdata_i;
            end
            if (wr_ctrl) begin
                next_ctrl = pwdata_i;
            end
            if (wr_count) begin
                // Larger requests saturate at eight
                next_cnt = (pwdata_i > DATA_W'(COUNT_MAX)) ? COUNT_MAX
                         : pwdata_i[CNT_W-1:0];
            end
            if (wr_level) begin
                next_lvl = pwdata_i[THR_NUM-1:0];
            end
            // Direction is trusted only alongside a pulse
            if (count_pulse_i) begin
                next_last_dir = count_dir_i;
                next_dir_seen = 1'b1;
            end
            if (!ctrl[CTRL_EN]) begin
                next_out_lvl = ctrl[CTRL_MAN];
            end else if (auto_on) begin
                if (en_rise) begin
                    if (count_pulse_i) begin
                        next_out_lvl = dir_dis ? 1'b0 : restore;
                    end else begin
                        next_out_lvl = old_dis ? 1'b0 : restore;
                    end
                    next_last_state  = next_out_lvl;
                    next_state_valid = 1'b1;
                end else if (count_pulse_i && !dir_dis && hit) begin
                    next_out_lvl     = hit_lvl;
                    next_last_state  = hit_lvl;
                    next_state_valid = 1'b1;
                end
            end
        end

        // Whole channel freezes while ce_i is low
        always_ff @(posedge mclk_i or negedge rst_sync_n) begin
            if (!rst_sync_n) begin
                ctrl        <= CTRL_RST;
                cnt         <= COUNT_RST;
                lvl         <= LEVEL_RST;
                thr         <= '{default: THR_RST};
                out_lvl     <= 1'b0;
                last_state  <= 1'b0;
                state_valid <= 1'b0;
                last_dir    <= 1'b0;
                dir_seen    <= 1'b0;
                en_d        <= 1'b0;
            end else if (ce_i) begin
                ctrl        <= next_ctrl;
                cnt         <= next_cnt;
                lvl         <= next_lvl;
                thr         <= next_thr;
                out_lvl     <= next_out_lvl;
                last_state  <= next_last_state;
                state_valid <= next_state_valid;
                last_dir    <= next_last_dir;
                dir_seen    <= next_dir_seen;
                en_d        <= next_en_d;
            end
        end

        assign out_q[c] = out_lvl;

        // Unmapped offsets read zero; the error flag is set elsewhere
        always_comb begin
            rd_word[c] = '0;
            if (sel_thr) begin
                rd_word[c] = thr[thr_idx];
            end else if (sel_ctrl) begin
                rd_word[c] = ctrl;
            end else if (sel_count) begin
                rd_word[c][CNT_W-1:0] = cnt;
            end else if (sel_level) begin
                rd_word[c][THR_NUM-1:0] = lvl;
            end else if (sel_status) begin
                rd_word[c][STAT_OUT]      = out_lvl;
                rd_word[c][STAT_VALID]    = state_valid;
                rd_word[c][STAT_DIR]      = last_dir;
                rd_word[c][STAT_DIR_SEEN] = dir_seen;
            end
        end
    end
endmodule

`default_nettype wire
